// ---- rtl/sadc_pkg.sv ----
package sadc_pkg;
  // output word layout
  localparam int unsigned RESULT_BITS      = 12;
  localparam int unsigned LEAD_ZERO_BITS   = 2;
  localparam int unsigned WORD_BITS        = 14;
  // clock counts per frame
  localparam logic [5:0]  DATA_EDGES       = 6'h0E;
  localparam logic [5:0]  PWRUP_CAL_EDGES  = 6'h10;
  localparam logic [5:0]  CAL_START_EDGE   = 6'h11;
  localparam logic [5:0]  CAL_DONE_EDGE    = 6'h20;
  // conversion finishes after the last result bit
  localparam logic [5:0]  CONV_DONE_EDGE   = 6'h0D;
  // code points of the transfer curve
  localparam logic [11:0] NEG_FULL_SCALE_CODE = 12'h000;
  localparam logic [11:0] MID_SCALE_CODE      = 12'h800;
  localparam logic [11:0] POS_FULL_SCALE_CODE = 12'hFFF;
  localparam logic [11:0] OFFSET_RESET        = 12'h000;
  // host side timing, kept for reference; neither the rtl nor the bench uses it
  localparam int unsigned SETUP_TIME_NS    = 15;
  localparam int unsigned ACQ_TIME_NS      = 200;
  localparam int unsigned CORE_CLK_MHZ     = 10;
  localparam int unsigned ACQ_CYCLES       = (ACQ_TIME_NS * CORE_CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    SADC_IDLE  = 2'b00,
    SADC_CONV  = 2'b01,
    SADC_TAIL  = 2'b10
  } sadc_state_t;
endpackage

// ---- rtl/sadc_readout.sv ----
// Notes on behaviour
// - select falling edge captures the input sample and starts conversion
// - conversion and shifting are timed only by the host serial clock
// - inputs isolated during conversion, reconnected for acquisition after it
// - results are unsigned straight binary
// - code 000 most negative, 800 zero, FFF most positive
// - a frame runs from select falling edge to select rising edge
// - word is two zero bits then twelve result bits
// - first zero at select fall, later bits on serial clock falls
// - after fourteen serial clocks output stays low until frame end
// - select rising edge ends frame and releases the data output
// - first frame after power-up calibrates; output stays low throughout
// - inputs stay disconnected while calibration runs
// - first frame clock count decides calibrated or uncalibrated operation
// - host may request calibration during normal operation
// - offset store is internal, not reachable through serial port
// - offset store clears to zero at power-up
// - only analog supply power cycle clears calibration
// - power-up calibration needs sixteen clocks in first frame
// - normal calibration needs 32 clocks, runs edges 17 to 32
// - results are corrected by stored offset before shifting out
`timescale 1ns/1ns
`default_nettype none
module sadc_readout
  import sadc_pkg::*;
(
  // core clock and power-up reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // serial link from host
  input  wire logic        select_n_i,
  input  wire logic        serial_clk_i,
  // analog front end
  input  wire logic [11:0] raw_code_i,
  input  wire logic [11:0] cal_measure_i,
  output logic             sample_hold_o,
  output logic             inputs_connected_o,
  // serial data pin
  output logic             data_o,
  output logic             data_oe_o,
  // status
  output logic             calibrated_o
);

  logic [1:0]  sel_sync_reg;
  logic [1:0]  sck_sync_reg;
  logic        sel_d_reg;
  logic        sck_d_reg;
  logic        sel_fall;
  logic        sel_rise;
  logic        sck_fall;
  logic        in_frame;
  sadc_state_t state_reg;
  logic [5:0]  edge_cnt_reg;
  logic [13:0] shift_reg;
  logic [11:0] offset_reg;
  logic        first_frame_reg;
  logic        calibrated_reg;
  logic        cal_run_reg;
  logic [11:0] corrected;

  // pins are asynchronous to the core clock
  // reset to idle levels so no false edge follows reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_sync_reg <= 2'h3;
      sck_sync_reg <= 2'h3;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], select_n_i};
      sck_sync_reg <= {sck_sync_reg[0], serial_clk_i};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_d_reg <= 1'b1;
      sck_d_reg <= 1'b1;
    end else begin
      sel_d_reg <= sel_sync_reg[1];
      sck_d_reg <= sck_sync_reg[1];
    end
  end

  assign sel_fall = sel_d_reg && !sel_sync_reg[1];
  assign sel_rise = !sel_d_reg && sel_sync_reg[1];
  assign in_frame = !sel_sync_reg[1];
  assign sck_fall = sck_d_reg && !sck_sync_reg[1] && in_frame && !sel_fall;

  // offset correction, saturating at the ends of the scale
  always_comb begin
    logic signed [13:0] diff;
    diff = $signed({2'b00, raw_code_i}) - $signed({2'b00, offset_reg});
    if (diff < 14'sd0) begin
      corrected = NEG_FULL_SCALE_CODE;
    end else if (diff > $signed({2'b00, POS_FULL_SCALE_CODE})) begin
      corrected = POS_FULL_SCALE_CODE;
    end else begin
      corrected = diff[11:0];
    end
  end

  // serial clock falling edges in this frame, saturating
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_cnt_reg <= 6'h00;
    end else if (sel_fall) begin
      edge_cnt_reg <= 6'h00;
    end else if (sck_fall && edge_cnt_reg != 6'h3F) begin
      edge_cnt_reg <= edge_cnt_reg + 6'h01;
    end
  end

  // conversion framing
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= SADC_IDLE;
    end else if (sel_rise) begin
      state_reg <= SADC_IDLE;
    end else begin
      case (state_reg)
        SADC_IDLE: begin
          if (sel_fall) begin
            state_reg <= SADC_CONV;
          end
        end
        SADC_CONV: begin
          if (sck_fall && edge_cnt_reg + 6'h01 >= CONV_DONE_EDGE) begin
            state_reg <= SADC_TAIL;
          end
        end
        SADC_TAIL: begin
          state_reg <= SADC_TAIL;
        end
        default: begin
          state_reg <= SADC_IDLE;
        end
      endcase
    end
  end

  // isolate inputs during conversion and calibration
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inputs_connected_o <= 1'b1;
      sample_hold_o      <= 1'b0;
    end else begin
      sample_hold_o <= sel_fall;
      // calibration keeps inputs off the sampling stage
      inputs_connected_o <= !((state_reg == SADC_CONV && !sel_rise) || sel_fall
                              || (cal_run_reg && !sel_rise));
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_reg <= 14'h0000;
    end else if (sel_fall) begin
      shift_reg <= 14'h0000;
    end else if (sck_fall && edge_cnt_reg == 6'h00) begin
      // straight binary, corrected; zeros in first frame
      shift_reg <= first_frame_reg ? 14'h0000 : {corrected, 2'b00};
    end else if (sck_fall) begin
      shift_reg <= {shift_reg[12:0], 1'b0};
    end
  end

  // launch bits; low after fourteen; release on rise
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o    <= 1'b0;
      data_oe_o <= 1'b0;
    end else if (sel_rise || !in_frame) begin
      data_o    <= 1'b0;
      data_oe_o <= 1'b0;
    end else if (sel_fall) begin
      data_o    <= 1'b0;
      data_oe_o <= 1'b1;
    end else if (sck_fall) begin
      data_oe_o <= 1'b1;
      if (edge_cnt_reg == 6'h00) begin
        data_o <= 1'b0;
      end else if (edge_cnt_reg < DATA_EDGES) begin
        data_o <= shift_reg[13];
      end else begin
        data_o <= 1'b0;
      end
    end
  end

  // calibration; store has no port access
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offset_reg      <= OFFSET_RESET;
      first_frame_reg <= 1'b1;
      calibrated_reg  <= 1'b0;
      cal_run_reg     <= 1'b0;
    end else begin
      if (sel_fall && first_frame_reg) begin
        cal_run_reg <= 1'b1;
      end else if (sck_fall && !first_frame_reg && edge_cnt_reg + 6'h01 == CAL_START_EDGE) begin
        cal_run_reg <= 1'b1;
      end
      if (sel_rise) begin
        cal_run_reg     <= 1'b0;
        first_frame_reg <= 1'b0;
      end
      if (sck_fall && first_frame_reg && edge_cnt_reg + 6'h01 == PWRUP_CAL_EDGES) begin
        offset_reg     <= cal_measure_i;
        calibrated_reg <= 1'b1;
        cal_run_reg    <= 1'b0;
      end else if (sck_fall && cal_run_reg && !first_frame_reg
                   && edge_cnt_reg + 6'h01 == CAL_DONE_EDGE) begin
        offset_reg     <= cal_measure_i;
        calibrated_reg <= 1'b1;
        cal_run_reg    <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      calibrated_o <= 1'b0;
    end else begin
      calibrated_o <= calibrated_reg;
    end
  end

  // data released one cycle after frame end is seen
  release_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sel_rise |=> !data_oe_o) else $error("data not released");
  // first bit is zero and driven
  first_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sel_fall |=> data_oe_o && !data_o) else $error("first zero missing");
  // pin stays driven while select is low
  oe_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    in_frame && !sel_fall |=> data_oe_o) else $error("oe dropped in frame");
  // low after fourteen clocks
  tail_low_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sck_fall && edge_cnt_reg >= DATA_EDGES |=> !data_o) else $error("tail not low");
  // first frame carries only zeros
  cal_frame_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    first_frame_reg && in_frame && !sel_fall |=> !data_o) else $error("first frame data");
  // isolation during conversion
  isolate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == SADC_CONV && !sel_rise |=> !inputs_connected_o) else $error("inputs on");
  // conversion over, inputs back for acquisition
  reconnect_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == SADC_TAIL && !cal_run_reg |=> inputs_connected_o) else $error("no reconnect");
  // frame start begins conversion
  conv_start_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sel_fall |=> state_reg == SADC_CONV ##0 sample_hold_o) else $error("no start");
  // one sample pulse per frame start
  one_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sample_hold_o |=> !sample_hold_o) else $error("long sample pulse");
  // store changes only on qualifying edge
  store_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !sck_fall |=> $stable(offset_reg)) else $error("offset moved");
  // long frame starts calibration on fall seventeen
  cal_begin_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sck_fall && !first_frame_reg && edge_cnt_reg + 6'h01 == CAL_START_EDGE
    |=> cal_run_reg) else $error("cal not started");
  // fall thirty-two of a long frame ends calibration and sets calibrated
  long_done_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sck_fall && cal_run_reg && !first_frame_reg && edge_cnt_reg + 6'h01 == CAL_DONE_EDGE
    |=> calibrated_reg && !cal_run_reg) else $error("long cal not done");
  // sixteen falls in first frame load the store
  pwrup_done_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sck_fall && first_frame_reg && edge_cnt_reg + 6'h01 == PWRUP_CAL_EDGES
    |=> calibrated_reg && offset_reg == $past(cal_measure_i)) else $error("cal not stored");
  // calibration isolates inputs
  cal_isolate_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    cal_run_reg && !sel_rise |=> !inputs_connected_o) else $error("cal inputs on");
  // short first frame leaves store at reset value
  short_cal_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !calibrated_reg |-> offset_reg == OFFSET_RESET) else $error("store not clear");

  // main scenarios for coverage
  pwrup_cal_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    first_frame_reg ##1 calibrated_reg);
  long_cal_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !first_frame_reg && cal_run_reg);
  data_one_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    data_oe_o && data_o);
  short_frame_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sel_rise && edge_cnt_reg < DATA_EDGES);
  tail_clock_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    state_reg == SADC_TAIL && sck_fall);

endmodule
`default_nettype wire

// ---- tb/sadc_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sadc_host_model (
  // frame request
  input  wire logic       start_i,
  input  wire logic [5:0] n_clk_i,
  // link pins
  output logic            select_n_o,
  output logic            serial_clk_o,
  input  wire logic       pin_i,
  input  wire logic       data_oe_i,
  input  wire logic       connected_i,
  // what the frame showed
  output logic            done_o,
  output logic [13:0]     word_o,
  output logic            tail_one_o,
  output logic            oe_lost_o,
  output logic            conn_mid_o
);
  initial begin
    select_n_o = 1'b1;
    serial_clk_o = 1'b1;
    done_o = 1'b0;
  end
  // clock idles high, so every frame edge seen first is a fall
  always @(posedge start_i) begin : frame
    int k;
    done_o = 1'b0;
    word_o = 14'h0000;
    tail_one_o = 1'b0;
    oe_lost_o = 1'b0;
    conn_mid_o = 1'b1;
    #37;
    select_n_o = 1'b0;
    #800;
    for (k = 1; k <= n_clk_i; k++) begin
      // bit of previous fall read just before this fall
      if (k <= 14) begin
        word_o = {word_o[12:0], pin_i};
      end else if (pin_i !== 1'b0) begin
        tail_one_o = 1'b1;
      end
      if (data_oe_i !== 1'b1) begin
        oe_lost_o = 1'b1;
      end
      if (k == 2) begin
        conn_mid_o = connected_i;
      end
      // link clock slowed for the bench
      serial_clk_o = 1'b0;
      #400;
      serial_clk_o = 1'b1;
      #400;
    end
    select_n_o = 1'b1;
    #1200;
    done_o = 1'b1;
  end
endmodule
`default_nettype wire

// ---- tb/sar_adc_serial_readout_cal_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module sar_adc_serial_readout_cal_tb_top
  import sadc_pkg::*;
;
  logic        core_clk, rst_n, select_n, serial_clk, sample_hold, connected;
  logic        data, data_oe, calibrated, tog, pin, start, done;
  logic        tail_one, oe_lost, conn_mid;
  logic [11:0] raw_code, cal_measure;
  logic [5:0]  n_clk;
  logic [13:0] word;
  logic [31:0] seed;
  int          fail_count, checked, cyc, holds;
  // released pin shows a toggling pattern, never a stale bit
  assign pin = data_oe ? data : tog;
  sadc_readout sadc_readout_inst (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .select_n_i(select_n), .serial_clk_i(serial_clk), .raw_code_i(raw_code),
    .cal_measure_i(cal_measure), .sample_hold_o(sample_hold),
    .inputs_connected_o(connected), .data_o(data), .data_oe_o(data_oe),
    .calibrated_o(calibrated));
  sadc_host_model sadc_host_model_inst (.start_i(start), .n_clk_i(n_clk),
    .select_n_o(select_n), .serial_clk_o(serial_clk), .pin_i(pin),
    .data_oe_i(data_oe), .connected_i(connected), .done_o(done), .word_o(word),
    .tail_one_o(tail_one), .oe_lost_o(oe_lost), .conn_mid_o(conn_mid));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    tog <= rst_n ? ~tog : 1'b0;
    if (sample_hold === 1'b1) holds++;
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin : main
    int n_tab [12];
    int i, offset, exp, w, lim, h0;
    bit first, cal;
    n_tab = '{10, 14, 14, 14, 20, 32, 14, 14, 16, 14, 40, 14};
    rst_n = 1'b0; start = 1'b0; n_clk = 6'h00;
    raw_code = 12'h000; cal_measure = 12'h000; seed = 32'd54882;
    for (i = 0; i < 12; i++) begin
      // second reset mid-run stands for an analog supply cycle
      if (i == 0 || i == 8) begin
        @(posedge core_clk) rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        offset = 0; cal = 0; first = 1;
        @(posedge core_clk);
        check("calibrated after reset", {15'h0000, calibrated}, 16'h0000);
      end
      seed = xorshift(seed);
      @(posedge core_clk);
      raw_code <= (i == 1) ? 12'h000 : (i == 2) ? 12'h800 : (i == 3) ? 12'hFFF : seed[11:0];
      cal_measure <= {5'h00, seed[18:12]};
      n_clk <= n_tab[i][5:0];
      h0 = holds;
      start <= 1'b1;
      lim = 0;
      @(posedge core_clk);
      while (done !== 1'b1 && lim < 1000) begin
        @(posedge core_clk);
        lim++;
      end
      start <= 1'b0;
      check("frame finished", {15'h0000, done}, 16'h0001);
      exp = first ? 0 : int'(raw_code) - offset;
      if (exp < 0) exp = 0;
      w = (n_tab[i] < WORD_BITS) ? exp >> (WORD_BITS - n_tab[i]) : exp;
      check("frame word", {2'b00, word}, w[15:0]);
      check("tail bits", {15'h0000, tail_one}, 16'h0000);
      check("oe in frame", {15'h0000, oe_lost}, 16'h0000);
      check("inputs in conversion", {15'h0000, conn_mid}, 16'h0000);
      check("oe after frame", {15'h0000, data_oe}, 16'h0000);
      check("inputs after frame", {15'h0000, connected}, 16'h0001);
      check("sample pulses", 16'(holds - h0), 16'h0001);
      if (first ? n_tab[i] >= 16 : n_tab[i] >= 32) begin
        offset = int'(cal_measure);
        cal = 1;
      end
      first = 0;
      check("calibrated", {15'h0000, calibrated}, {15'h0000, cal});
    end
    test_done();
  end
endmodule
`default_nettype wire
